/* rtl/mmc_pkg.sv */
// Package: offsets, field positions, reset values and shared types of the memory map block
package mmc_pkg;
  localparam logic [7:0] MMC_PSW_ADDR  = 8'h8e;
  localparam logic [7:0] MMC_AUX_ADDR  = 8'ha2;
  localparam logic [7:0] MMC_FLASH_CONTROL_ADDR = 8'hd1;
  localparam logic [7:0] MMC_PTRH_ADDR = 8'h83;
  localparam logic [7:0] MMC_PTRL_ADDR = 8'h84;
  localparam logic [7:0] MMC_SFR_BASE  = 8'h80;
  localparam logic [7:0] MMC_BIT_BASE  = 8'h20;
  localparam logic [7:0] MMC_FLASH_CONTROL_RST  = 8'h00;
  localparam logic [7:0] MMC_PSW_RST   = 8'h00;
  localparam logic [7:0] MMC_AUX_RST   = 8'h00;
  localparam logic [3:0] MMC_KEY_ARM   = 4'h5;
  localparam logic [3:0] MMC_KEY_GO    = 4'ha;
  localparam int         MMC_FC_LATCH  = 3;
  localparam int         MMC_FC_BUSY   = 0;
  localparam int         MMC_AUX_SEL   = 0;
  localparam int         MMC_AUX_ZERO  = 2;
  localparam int         MMC_AUX_GF    = 3;
  localparam int         MMC_AUX_BOOT  = 5;
  localparam int         MMC_PSW_CY    = 7;
  localparam int         MMC_PSW_AC    = 6;
  localparam int         MMC_PSW_OV    = 2;
  localparam int         MMC_PSW_P     = 0;
  localparam logic [7:0] MMC_AUX_WMASK = 8'h29;
  localparam logic [15:0] MMC_USER_LO  = 16'h0000;
  localparam logic [15:0] MMC_USER_HI  = 16'h3fff;
  localparam logic [15:0] MMC_XROW_LO  = 16'hff80;
  localparam logic [15:0] MMC_SEC_ADDR = 16'h0000;
  localparam logic [15:0] MMC_BOOT_LO  = 16'hf800;
  localparam logic [1:0] MMC_SPACE_USER = 2'b00;
  localparam logic [1:0] MMC_SPACE_XROW = 2'b01;
  localparam logic [1:0] MMC_SPACE_SEC  = 2'b10;
  localparam logic [1:0] MMC_SPACE_RSVD = 2'b11;

  typedef enum logic [2:0]
  {
    MMC_IDLE  = 3'b001,
    MMC_ARMED = 3'b010,
    MMC_BUSY  = 3'b100
  } mmc_key_st_t;

  // Internal data memory target of one access
  typedef enum logic [3:0]
  {
    MMC_T_LOW  = 4'b0001,
    MMC_T_UP   = 4'b0010,
    MMC_T_SFR  = 4'b0100,
    MMC_T_XRAM = 4'b1000
  } mmc_tgt_t;

  // Flag updates from the core's arithmetic unit
  typedef struct packed
  {
    logic wr_cy;
    logic cy;
    logic wr_ac;
    logic ac;
    logic wr_ov;
    logic ov;
  } mmc_alu_t;

  // One data memory access from the core
  typedef struct packed
  {
    logic        valid;
    logic        direct;
    logic        movx;
    logic        bit_op;
    logic [15:0] addr;
  } mmc_acc_t;

  // Decoded access handed to the memories
  typedef struct packed
  {
    logic        low_ram;
    logic        up_ram;
    logic        sfr;
    logic        xram;
    logic        latch;
    logic [7:0]  ram_addr;
    logic [2:0]  bit_pos;
  } mmc_dec_t;
endpackage

/* rtl/mmc_regs.sv */
// Memory map decode, flash control, program status and auxiliary registers
`timescale 1ns/1ps
module mmc_regs
  import mmc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 16
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  input  wire logic [7:0]  i_accumulator,
  input  wire mmc_alu_t    i_alu,
  input  wire mmc_acc_t    i_acc,
  input  wire logic        i_prog_done,
  output logic [7:0]       o_sfr_rdata,
  output logic             o_sfr_hit,
  output mmc_dec_t         o_dec,
  output logic [15:0]      o_active_pointer,
  output logic             o_prog_start,
  output logic [1:0]       o_prog_space,
  output logic             o_cpu_idle,
  output logic [1:0]       o_flash_space_select,
  output logic             o_latch_window_select,
  output logic             o_boot_area_map
);

  // Elaboration checks: the logic hard-wires field slices and the counter width
  if (PROG_CYCLES < 1 || PROG_CYCLES > 65535)
  begin : g_chk_prog
    $error("PROG_CYCLES out of range");
  end

  if (MMC_KEY_ARM == MMC_KEY_GO)
  begin : g_chk_key
    $error("launch key codes must differ");
  end

  if (MMC_FC_LATCH != 3 || MMC_FC_BUSY != 0)
  begin : g_chk_fc
    $error("flash control fields must match the fixed slices");
  end

  if (MMC_FLASH_CONTROL_RST[MMC_FC_BUSY] != 1'b0)
  begin : g_chk_busy
    $error("busy flag must reset clear");
  end

  if (MMC_AUX_WMASK[MMC_AUX_ZERO] != 1'b0)
  begin : g_chk_aux
    $error("aux stuck-zero bit must not be writable");
  end

  if (MMC_BIT_BASE + 8'h0f >= MMC_SFR_BASE)
  begin : g_chk_bit
    $error("bit area must lie inside lower RAM");
  end

  if (MMC_PSW_OV == 3 || MMC_PSW_OV == 4 || MMC_PSW_P == 3 || MMC_PSW_P == 4)
  begin : g_chk_psw
    $error("status flags must not overlap the bank select field");
  end

  localparam logic [15:0] PROG_LEN = 16'(PROG_CYCLES);

  typedef struct packed
  {
    mmc_key_st_t key;
    logic [3:0]  fc_key;
    logic        latch;
    logic [1:0]  space;
    logic        busy;
    logic [15:0] cnt;
    logic [7:0]  program_status;
    logic        sel;
    logic        gf3;
    logic        boot;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [15:0] act;
    logic        start;
    logic [1:0]  prog_space;
    logic [7:0]  rdata;
    logic        hit;
    mmc_dec_t    dec;
  } mmc_state_t;

  mmc_state_t s_q;
  mmc_state_t s_d;

  logic       wr_fc;
  logic       wr_aux;
  logic       wr_psw;
  logic [7:0] aux_val;
  logic [7:0] fc_val;
  logic [15:0] ptr_cur;

  always_comb
  begin
    wr_fc   = i_sfr_wr && (i_sfr_addr == MMC_FLASH_CONTROL_ADDR);
    wr_aux  = i_sfr_wr && (i_sfr_addr == MMC_AUX_ADDR);
    wr_psw  = i_sfr_wr && (i_sfr_addr == MMC_PSW_ADDR);
    fc_val  = {s_q.fc_key, s_q.latch, s_q.space, s_q.busy};
    aux_val = 8'h00;
    aux_val[MMC_AUX_SEL]  = s_q.sel;
    aux_val[MMC_AUX_ZERO] = 1'b0;
    aux_val[MMC_AUX_GF]   = s_q.gf3;
    aux_val[MMC_AUX_BOOT] = s_q.boot;
    ptr_cur = s_q.sel ? s_q.ptr1 : s_q.ptr0;

    s_d       = s_q;
    s_d.start = 1'b0;

    // Launch key sequencer; software writes never touch the busy bit
    if (wr_fc)
    begin
      s_d.fc_key = i_sfr_wdata[7:4];
      s_d.latch  = i_sfr_wdata[MMC_FC_LATCH];
      s_d.space  = i_sfr_wdata[2:1];
    end
    unique case (s_q.key)
      MMC_IDLE:
      begin
        if (wr_fc && i_sfr_wdata[7:4] == MMC_KEY_ARM)
        begin
          s_d.key = MMC_ARMED;
        end
      end
      MMC_ARMED:
      begin
        if (wr_fc)
        begin
          if (i_sfr_wdata[7:4] == MMC_KEY_GO && i_sfr_wdata[2:1] != MMC_SPACE_RSVD)
          begin
            // Reserved space code is no action
            s_d.key        = MMC_BUSY;
            s_d.busy       = 1'b1;
            s_d.start      = 1'b1;
            s_d.prog_space = i_sfr_wdata[2:1];
            s_d.cnt        = PROG_LEN;
          end
          else if (i_sfr_wdata[7:4] != MMC_KEY_ARM && i_sfr_wdata[7:4] != MMC_KEY_GO)
          begin
            // Key A on the reserved space is refused but leaves the arm in place
            s_d.key = MMC_IDLE;
          end
        end
      end
      MMC_BUSY:
      begin
        // Ends on the engine's done or, failing that, on the timeout count
        if (s_q.cnt != 16'h0000)
        begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
        if (i_prog_done || s_q.cnt == 16'h0001)
        begin
          s_d.key  = MMC_IDLE;
          s_d.busy = 1'b0;
          s_d.cnt  = 16'h0000;
        end
      end
    endcase

    // Program status: software write first, hardware flags override
    if (wr_psw)
    begin
      s_d.program_status = i_sfr_wdata;
    end
    if (i_alu.wr_cy)
    begin
      s_d.program_status[MMC_PSW_CY] = i_alu.cy;
    end
    if (i_alu.wr_ac)
    begin
      s_d.program_status[MMC_PSW_AC] = i_alu.ac;
    end
    if (i_alu.wr_ov)
    begin
      s_d.program_status[MMC_PSW_OV] = i_alu.ov;
    end
    s_d.program_status[MMC_PSW_P] = ^i_accumulator;

    // Reserved aux bits are not stored, so they read zero
    if (wr_aux)
    begin
      s_d.sel  = i_sfr_wdata[MMC_AUX_SEL];
      s_d.gf3  = i_sfr_wdata[MMC_AUX_GF];
      s_d.boot = i_sfr_wdata[MMC_AUX_BOOT];
    end

    // Both pointer bytes write into the selected pointer only
    if (i_sfr_wr && i_sfr_addr == MMC_PTRH_ADDR)
    begin
      if (s_q.sel)
      begin
        s_d.ptr1[15:8] = i_sfr_wdata;
      end
      else
      begin
        s_d.ptr0[15:8] = i_sfr_wdata;
      end
    end
    if (i_sfr_wr && i_sfr_addr == MMC_PTRL_ADDR)
    begin
      if (s_q.sel)
      begin
        s_d.ptr1[7:0] = i_sfr_wdata;
      end
      else
      begin
        s_d.ptr0[7:0] = i_sfr_wdata;
      end
    end

    // Registered copy keeps the pointer output straight off a flop
    s_d.act = s_d.sel ? s_d.ptr1 : s_d.ptr0;

    // Special register read port
    s_d.hit   = 1'b0;
    s_d.rdata = 8'h00;
    if (i_sfr_rd)
    begin
      s_d.hit = 1'b1;
      unique case (i_sfr_addr)
        MMC_FLASH_CONTROL_ADDR: s_d.rdata = fc_val;
        MMC_PSW_ADDR:  s_d.rdata = s_q.program_status;
        MMC_AUX_ADDR:  s_d.rdata = aux_val;
        MMC_PTRH_ADDR: s_d.rdata = ptr_cur[15:8];
        MMC_PTRL_ADDR: s_d.rdata = ptr_cur[7:0];
        default:
        begin
          s_d.hit   = 1'b0;
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // Data memory decode, registered one cycle behind the request
    s_d.dec = '0;
    if (i_acc.valid)
    begin
      if (i_acc.movx)
      begin
        // Latch window takes precedence over expanded RAM
        s_d.dec.latch = s_q.latch;
        s_d.dec.xram  = !s_q.latch && (i_acc.addr[15:8] == 8'h00);
        s_d.dec.ram_addr = i_acc.addr[7:0];
      end
      else if (i_acc.bit_op)
      begin
        if (i_acc.addr[7])
        begin
          s_d.dec.sfr      = 1'b1;
          s_d.dec.ram_addr = {i_acc.addr[7:3], 3'b000};
        end
        else
        begin
          s_d.dec.low_ram  = 1'b1;
          s_d.dec.ram_addr = MMC_BIT_BASE + {4'h0, i_acc.addr[6:3]};
        end
        s_d.dec.bit_pos = i_acc.addr[2:0];
      end
      else if (i_acc.addr[7:0] < MMC_SFR_BASE)
      begin
        s_d.dec.low_ram  = 1'b1;
        s_d.dec.ram_addr = i_acc.addr[7:0];
        if (i_acc.addr[7:3] == 5'b00000)
        begin
          // Register operand: offset into the active bank
          s_d.dec.ram_addr = {3'b000, s_q.program_status[4:3], i_acc.addr[2:0]};
        end
      end
      else if (i_acc.direct)
      begin
        s_d.dec.sfr      = 1'b1;
        s_d.dec.ram_addr = i_acc.addr[7:0];
      end
      else
      begin
        s_d.dec.up_ram   = 1'b1;
        s_d.dec.ram_addr = i_acc.addr[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q            <= '0;
      s_q.key        <= MMC_IDLE;
      s_q.fc_key     <= MMC_FLASH_CONTROL_RST[7:4];
      s_q.latch      <= MMC_FLASH_CONTROL_RST[MMC_FC_LATCH];
      s_q.space      <= MMC_FLASH_CONTROL_RST[2:1];
      s_q.busy       <= MMC_FLASH_CONTROL_RST[MMC_FC_BUSY];
      s_q.program_status        <= MMC_PSW_RST;
      s_q.sel        <= MMC_AUX_RST[MMC_AUX_SEL];
      s_q.gf3        <= MMC_AUX_RST[MMC_AUX_GF];
      s_q.boot       <= MMC_AUX_RST[MMC_AUX_BOOT];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Register bank code is bits 4:3 of program status
  assign o_sfr_rdata           = s_q.rdata;
  assign o_sfr_hit             = s_q.hit;
  assign o_dec                 = s_q.dec;
  assign o_active_pointer      = s_q.act;
  assign o_prog_start          = s_q.start;
  assign o_prog_space          = s_q.prog_space;
  assign o_cpu_idle            = s_q.busy;
  assign o_flash_space_select  = s_q.space;
  assign o_latch_window_select = s_q.latch;
  assign o_boot_area_map       = s_q.boot;

endmodule

/* test/mmc_core_model.sv */
// Core model: special register reads and writes as the processor issues them
`timescale 1ns/1ps
module mmc_core_model
  import mmc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_hit,
  output logic            o_wr = 1'b0,
  output logic            o_rd = 1'b0,
  output logic [7:0]      o_addr = 8'h00,
  output logic [7:0]      o_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_wdata = (a == MMC_AUX_ADDR) ? (d & 8'h2d) : d;
    @(negedge i_clk);
    o_wr = 1'b0;
    // Released bus shows the inverse so stale values cannot pass
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    h = i_hit;
  endtask
endmodule

/* test/mmc_regs_assertions.sv */
// Checker: port-level assertions for the memory map register block
`timescale 1ns/1ps
module mmc_regs_checker
  import mmc_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_prog_done,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_sfr_hit,
  input wire logic       o_prog_start,
  input wire logic       o_cpu_idle,
  input wire logic [1:0] o_flash_space_select,
  input wire logic       o_latch_window_select,
  input wire logic       o_boot_area_map
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire fc_wr = i_sfr_wr && i_sfr_addr == MMC_FLASH_CONTROL_ADDR;
  wire go_wr = fc_wr && i_sfr_wdata[7:4] == MMC_KEY_GO;
  wire ax_wr = i_sfr_wr && i_sfr_addr == MMC_AUX_ADDR;
  sequence s_arm;
    fc_wr && i_sfr_wdata[7:4] == MMC_KEY_ARM && !o_cpu_idle;
  endsequence
  sequence s_go;
    go_wr && i_sfr_wdata[2:1] != MMC_SPACE_RSVD;
  endsequence
  a_key_launch: assert property (s_arm ##1 !i_sfr_wr ##1 s_go |=> o_prog_start)
    else $error("launch key sequence not accepted");
  a_start_cause: assert property (o_prog_start |-> $past(go_wr))
    else $error("launch without second key write");
  a_busy_idle: assert property (o_prog_start |-> o_cpu_idle)
    else $error("launch without idle hold");
  a_idle_release: assert property (o_cpu_idle && i_prog_done |-> ##[1:2] !o_cpu_idle)
    else $error("idle not released after programming");
  a_field_write: assert property (fc_wr |=> o_latch_window_select == $past(i_sfr_wdata[3])
    && o_flash_space_select == $past(i_sfr_wdata[2:1]))
    else $error("flash control fields not written");
  a_boot_write: assert property (ax_wr |=> o_boot_area_map == $past(i_sfr_wdata[5]))
    else $error("boot map bit not written");
  a_aux_zero: assert property (i_sfr_rd && i_sfr_addr == MMC_AUX_ADDR
    |=> o_sfr_hit && !o_sfr_rdata[MMC_AUX_ZERO])
    else $error("aux bit two not zero");
  a_ctl_reset: assert property (disable iff (1'b0) i_rst |=> !o_cpu_idle
    && !o_latch_window_select && o_flash_space_select == 2'b00)
    else $error("flash control not cleared by reset");
endmodule
bind mmc_regs mmc_regs_checker mmc_regs_checker_inst (.*);

/* test/mmc_regs_tb.sv */
// Testbench: directed scenarios for the memory map register block
`timescale 1ns/1ps
module mmc_regs_tb;
  import mmc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  accum = 8'h00;
  logic        done = 1'b0;
  mmc_alu_t    alu = '0;
  mmc_acc_t    acc = '0;
  logic        wr, rd, hit, start, idle, latch, boot;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] ptr;
  logic [1:0]  pspace, fsel;
  mmc_dec_t    dec;
  int          miscompares = 0;
  int          check_count = 0;
  int          starts = 0;
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (start === 1'b1) starts <= starts + 1;
  localparam int PROG = 40;
  mmc_regs #(.PROG_CYCLES(PROG)) mmc_regs_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_accumulator(accum),
    .i_alu(alu), .i_acc(acc), .i_prog_done(done), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .o_dec(dec), .o_active_pointer(ptr), .o_prog_start(start), .o_prog_space(pspace),
    .o_cpu_idle(idle), .o_flash_space_select(fsel), .o_latch_window_select(latch),
    .o_boot_area_map(boot));
  mmc_core_model mmc_core_model_inst (.i_clk(i_clk), .i_rdata(rdata), .i_hit(hit),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  logic [7:0] rv;
  logic       rh;
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task w(input logic [7:0] a, input logic [7:0] d);
    mmc_core_model_inst.wr(a, d);
  endtask
  task r(input logic [7:0] a);
    mmc_core_model_inst.rd(a, rv, rh);
  endtask
  task a(input logic d, input logic m, input logic b, input logic [15:0] ad);
    @(negedge i_clk);
    acc = '{1'b1, d, m, b, ad};
    @(negedge i_clk);
    acc = '0;
  endtask
  task t_reset;
    r(MMC_FLASH_CONTROL_ADDR); chk(rv, MMC_FLASH_CONTROL_RST);
    r(MMC_AUX_ADDR); chk(rv & 8'h0d, 8'h00);
    r(8'h90); chk({rh, rv}, 9'h000);
  endtask
  task t_launch;
    w(MMC_FLASH_CONTROL_ADDR, 8'ha0);
    w(MMC_FLASH_CONTROL_ADDR, 8'h56);
    w(MMC_FLASH_CONTROL_ADDR, 8'ha6); chk(starts[15:0], 16'h0000);
    w(MMC_FLASH_CONTROL_ADDR, 8'h52);
    w(MMC_FLASH_CONTROL_ADDR, 8'h30);
    w(MMC_FLASH_CONTROL_ADDR, 8'ha2); chk(starts[15:0], 16'h0000);
    w(MMC_FLASH_CONTROL_ADDR, 8'h52);
    w(MMC_FLASH_CONTROL_ADDR, 8'ha2); chk({start, idle, pspace}, {2'b11, MMC_SPACE_XROW});
    w(MMC_FLASH_CONTROL_ADDR, 8'h02); r(MMC_FLASH_CONTROL_ADDR); chk(rv[0], 1'b1);
    @(negedge i_clk);
    done = 1'b1;
    @(negedge i_clk);
    done = 1'b0;
    @(negedge i_clk);
    chk(idle, 1'b0);
    r(MMC_FLASH_CONTROL_ADDR); chk(rv[0], 1'b0);
    w(MMC_FLASH_CONTROL_ADDR, 8'h50);
    w(MMC_FLASH_CONTROL_ADDR, 8'ha6); chk(idle, 1'b0);
    w(MMC_FLASH_CONTROL_ADDR, 8'ha0); chk({start, idle}, 2'b11);
    // No done this time: busy must end on its own count
    repeat (PROG - 1) @(negedge i_clk);
    chk(idle, 1'b1);
    @(negedge i_clk);
    chk(idle, 1'b0);
  endtask
  task t_dec;
    w(MMC_FLASH_CONTROL_ADDR, 8'h0c); chk({latch, fsel}, {1'b1, MMC_SPACE_SEC});
    a(1'b0, 1'b1, 1'b0, 16'h0010); chk(dec.latch, 1'b1);
    w(MMC_FLASH_CONTROL_ADDR, 8'h00);
    a(1'b0, 1'b1, 1'b0, 16'h00ff); chk({dec.xram, dec.latch, dec.ram_addr}, 10'h2ff);
    a(1'b1, 1'b0, 1'b0, 16'h0090); chk({dec.sfr, dec.ram_addr}, 9'h190);
    a(1'b0, 1'b0, 1'b0, 16'h0090); chk({dec.up_ram, dec.ram_addr}, 9'h190);
    a(1'b1, 1'b0, 1'b0, 16'h0045); chk({dec.low_ram, dec.ram_addr}, 9'h145);
    a(1'b1, 1'b0, 1'b1, 16'h000b); chk({dec.ram_addr, dec.bit_pos}, 11'h10b);
    for (int b = 0; b < 4; b++)
    begin
      w(MMC_PSW_ADDR, 8'(b << 3));
      a(1'b0, 1'b0, 1'b0, 16'h0003); chk(dec.ram_addr, 16'(b * 8 + 3));
    end
  endtask
  task t_ptr;
    w(MMC_AUX_ADDR, 8'h00);
    w(MMC_PTRH_ADDR, 8'h12);
    w(MMC_PTRL_ADDR, 8'h34);
    w(MMC_AUX_ADDR, 8'h01);
    w(MMC_PTRH_ADDR, 8'h56);
    w(MMC_PTRL_ADDR, 8'h78); chk(ptr, 16'h5678);
    w(MMC_AUX_ADDR, 8'h00); chk(ptr, 16'h1234);
    w(MMC_AUX_ADDR, 8'h2d); r(MMC_AUX_ADDR); chk(rv & 8'h2d, 8'h29);
    chk(boot, 1'b1);
  endtask
  task t_psw;
    accum = 8'h07;
    w(MMC_PSW_ADDR, 8'h22); r(MMC_PSW_ADDR); chk(rv, 8'h23);
    accum = 8'h03;
    alu = 6'h3f;
    @(negedge i_clk);
    alu = '0;
    r(MMC_PSW_ADDR); chk({rh, rv}, 9'h1e6);
  endtask
  task end_of_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    t_reset();
    t_launch();
    t_dec();
    t_ptr();
    t_psw();
    end_of_test();
  end
  initial
  begin
    #50000;
    miscompares++;
    end_of_test();
  end
endmodule
